/* logic/flash_access_pkg.sv */
// Shared constants and types for flash sector access and protection
// What this block does
// - Erase whole array or one sector; program bytes
// - Sector erase leaves other sectors untouched
// - Sector count follows array size
// - Sectors 0,1 are 4K; sector 0 F000-FFFF
// - In-application mode never touches sector 0
// - Tool and in-circuit modes reach all sectors, options
// - Protection blocks readout and flash writes
// - Lifting protection first erases whole array
// - Option bit sets protection; masked parts fixed
// - Protection disables low-voltage detector, except on masked (IS_ROM) parts
// - Attached tool takes serial pins from application
// - One clock pin, one shared data pin
// - Application programming runs from sector 0 loader
package flash_access_pkg;

  localparam int          ADDR_W       = 16;
  localparam int          DATA_W       = 8;
  localparam int          KBYTE        = 1024;
  localparam int          ADDR_SPAN    = 65536;
  localparam int          ONE_SEC_KB   = 4;
  localparam int          TWO_SEC_KB   = 8;
  localparam logic [15:0] SEC0_BASE    = 16'hF000;
  localparam logic [15:0] SEC1_BASE    = 16'hE000;
  localparam logic [1:0]  SEC_IDX0     = 2'h0;
  localparam logic [1:0]  SEC_IDX1     = 2'h1;
  localparam logic [1:0]  SEC_IDX2     = 2'h2;
  localparam int          OPT_PROT_BIT = 0;

  // Operations toward the array and over the tool link
  typedef enum logic [2:0] {
    OP_NONE,
    OP_PROG,
    OP_ERASE_SEC,
    OP_ERASE_ALL,
    OP_OPT_WRITE
  } op_type;

  typedef struct packed {
    op_type      op;
    logic [15:0] addr;
    logic [7:0]  data;
  } arr_cmd_type;

  localparam int CMD_W = $bits(arr_cmd_type);

  // Link frame slots: start bit, payload, one response bit
  localparam logic [4:0] LINK_IDLE = 5'h00;
  localparam logic [4:0] LINK_LAST = 5'h1B;
  localparam logic [4:0] LINK_RESP = 5'h1C;

endpackage : flash_access_pkg

/* logic/flash_sector_access_protection.sv */
// Sector gating, read-out protection and tool link pin sharing
`timescale 1ns/100ps
module flash_sector_access_protection #(
  parameter int FLASH_KB    = 60,
  parameter bit IS_ROM      = 1'b0,
  parameter bit ROM_PROTECT = 1'b1
) (
  input  wire logic                     clk,
  input  wire logic                     rst_b,
  input  wire logic                     toolSerialClock,
  input  wire logic                     toolSerialDataIn,
  output logic                          toolSerialDataOut,
  output logic                          toolSerialDataOe,
  output logic                          toolSerialClockOut,
  output logic                          toolSerialClockOe,
  input  wire logic                     programmingVoltageSelect,
  input  wire logic                     toolAttached,
  input  wire logic                     socketMode,
  input  wire logic                     appDataOut,
  input  wire logic                     appDataOe,
  output logic                          appDataIn,
  input  wire logic                     appClockOut,
  input  wire logic                     appClockOe,
  input  wire logic                     bootInSector0,
  input  wire logic                     cpuReqValid,
  input  flash_access_pkg::arr_cmd_type cpuReq,
  output logic                          cpuReqReady,
  output logic                          cpuDone,
  output logic                          cpuRefused,
  output logic                          arrStart,
  output flash_access_pkg::arr_cmd_type arrCmd,
  input  wire logic                     arrBusy,
  input  wire logic                     optionProtect,
  input  wire logic                     lowVoltageDetectorReq,
  output logic                          lowVoltageDetectorEn,
  output logic                          readoutEnable,
  output logic                          readoutProtected
);

  // Array floor and number of sectors from the array size
  localparam logic [16:0] ARRAY_BASE = 17'(flash_access_pkg::ADDR_SPAN
                                     - FLASH_KB * flash_access_pkg::KBYTE);
  localparam logic [1:0] SECTORS =
    (FLASH_KB <= flash_access_pkg::ONE_SEC_KB) ? 2'h1 :
    (FLASH_KB <= flash_access_pkg::TWO_SEC_KB) ? 2'h2 : 2'h3;

  typedef enum {ST_IDLE, ST_WAIT, ST_UNPROT} state_type;

  state_type                     state_r;
  logic [3:0]                    pinSync1_r;
  logic [3:0]                    pinSync2_r;
  logic [2:0]                    tglSync_r;
  logic                          sessionOn;
  logic                          attached;
  logic                          inSocket;
  logic                          newFrame;
  logic                          frameTgl;
  flash_access_pkg::arr_cmd_type frameWord;
  logic                          linkOut;
  logic                          linkOe;
  logic                          linkPend_r;
  flash_access_pkg::arr_cmd_type linkCmd_r;
  logic                          protect_r;
  logic                          loaded_r;
  logic                          ownerCpu_r;
  logic                          takeLink;
  logic                          takeCpu;
  flash_access_pkg::arr_cmd_type selCmd;
  logic                          fromLink;
  logic [1:0]                    sector;
  logic                          inArray;
  logic                          isWrite;
  logic                          optClear;
  logic                          allowed;
  logic                          goWrite;
  logic                          goUnprot;
  logic                          goOptSet;
  logic                          finish;

  // Sector holding an address: top 4K is sector 0
  function automatic logic [1:0] sectorOf(input logic [15:0] a);
    if (a >= flash_access_pkg::SEC0_BASE) begin
      return flash_access_pkg::SEC_IDX0;
    end else if (a >= flash_access_pkg::SEC1_BASE) begin
      return flash_access_pkg::SEC_IDX1;
    end
    return flash_access_pkg::SEC_IDX2;
  endfunction : sectorOf

  // First byte of a sector; sector 2 runs from the array floor
  function automatic logic [15:0] sectorBase(input logic [1:0] s);
    if (s == flash_access_pkg::SEC_IDX0) begin
      return flash_access_pkg::SEC0_BASE;
    end else if (s == flash_access_pkg::SEC_IDX1) begin
      return flash_access_pkg::SEC1_BASE;
    end
    return ARRAY_BASE[15:0];
  endfunction : sectorBase

  // Pins from outside: two flops before use
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      pinSync1_r <= 4'h0;
      pinSync2_r <= 4'h0;
    end else begin
      pinSync1_r <= {programmingVoltageSelect, toolAttached, socketMode,
                     toolSerialDataIn};
      pinSync2_r <= pinSync1_r;
    end
  end

  assign sessionOn = pinSync2_r[3];
  assign attached  = pinSync2_r[2];
  assign inSocket  = pinSync2_r[1];

  // Attached tool owns both pins; link flops only count inside a session
  assign toolSerialDataOut  = attached ? linkOut : appDataOut;
  assign toolSerialDataOe   = attached ? (linkOe & sessionOn)
                                       : appDataOe;
  assign toolSerialClockOut = appClockOut;
  assign toolSerialClockOe  = appClockOe & ~attached;
  assign appDataIn          = pinSync2_r[0] & ~attached;

  tool_link_port linkPort (
    .linkClk   (toolSerialClock),
    .sessionOn (sessionOn),
    .readyLevel(~linkPend_r),
    .dataIn    (toolSerialDataIn),
    .dataOut   (linkOut),
    .dataOe    (linkOe),
    .frameTgl  (frameTgl),
    .frameWord (frameWord)
  );

  // Frame toggle crossing; only the later flops feed the edge detect
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      tglSync_r <= 3'h0;
    end else begin
      tglSync_r <= {tglSync_r[1:0], frameTgl};
    end
  end

  assign newFrame = (tglSync_r[1] ^ tglSync_r[2]) & sessionOn;

  // Pending link command; a new frame wins over the take
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      linkPend_r <= 1'b0;
    end else if (newFrame) begin
      linkPend_r <= 1'b1;
    end else if (takeLink) begin
      linkPend_r <= 1'b0;
    end
  end

  // Word is stable for many cycles once the toggle is seen
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      linkCmd_r <= '0;
    end else if (newFrame) begin
      linkCmd_r <= frameWord;
    end
  end

  // Link first, then processor; only when idle and options loaded
  always_comb begin
    takeLink = 1'b0;
    takeCpu  = 1'b0;
    selCmd   = linkCmd_r;
    fromLink = 1'b1;
    if (state_r == ST_IDLE && loaded_r) begin
      if (linkPend_r) begin
        takeLink = 1'b1;
      end else if (cpuReqValid) begin
        takeCpu  = 1'b1;
        selCmd   = cpuReq;
        fromLink = 1'b0;
      end
    end
  end

  assign cpuReqReady = takeCpu;
  assign sector      = sectorOf(selCmd.addr);
  assign inArray     = {1'b0, selCmd.addr} >= ARRAY_BASE;
  assign isWrite     = selCmd.op == flash_access_pkg::OP_PROG ||
                       selCmd.op == flash_access_pkg::OP_ERASE_SEC ||
                       selCmd.op == flash_access_pkg::OP_ERASE_ALL;
  assign optClear    = selCmd.op == flash_access_pkg::OP_OPT_WRITE &&
                       !selCmd.data[flash_access_pkg::OPT_PROT_BIT];

  // Permission by source, mode and protection
  always_comb begin
    allowed = !IS_ROM && selCmd.op != flash_access_pkg::OP_NONE;
    if (protect_r && isWrite) begin
      allowed = 1'b0;
    end
    if (selCmd.op != flash_access_pkg::OP_ERASE_ALL &&
        selCmd.op != flash_access_pkg::OP_OPT_WRITE && !inArray) begin
      allowed = 1'b0;
    end
    if (fromLink) begin
      // Socket or in-circuit session: every sector and options
      if (!sessionOn && !inSocket) begin
        allowed = 1'b0;
      end
    end else begin
      if (!bootInSector0) begin
        allowed = 1'b0;
      end
      if (sector == flash_access_pkg::SEC_IDX0 ||
          selCmd.op == flash_access_pkg::OP_ERASE_ALL ||
          selCmd.op == flash_access_pkg::OP_OPT_WRITE) begin
        allowed = 1'b0;
      end
    end
  end

  // Refused requests simply never reach the array
  assign goWrite  = (takeLink | takeCpu) & allowed & isWrite;
  assign goUnprot = (takeLink | takeCpu) & allowed & optClear & protect_r;
  assign goOptSet = (takeLink | takeCpu) & allowed & !protect_r &
                    selCmd.op == flash_access_pkg::OP_OPT_WRITE &&
                    selCmd.data[flash_access_pkg::OPT_PROT_BIT];
  assign finish   = !arrStart && !arrBusy;

  // Sequencer; busy is expected from the edge that samples the start
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      state_r <= ST_IDLE;
    end else begin
      unique case (state_r)
        ST_IDLE: begin
          if (goWrite) begin
            state_r <= ST_WAIT;
          end else if (goUnprot) begin
            state_r <= ST_UNPROT;
          end
        end
        ST_WAIT: begin
          if (finish) begin
            state_r <= ST_IDLE;
          end
        end
        ST_UNPROT: begin
          if (finish) begin
            state_r <= ST_IDLE;
          end
        end
      endcase
    end
  end

  // Array command; sector erase carries only its own sector base
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      arrStart <= 1'b0;
      arrCmd   <= '0;
    end else begin
      arrStart <= goWrite | goUnprot;
      if (goWrite) begin
        arrCmd <= selCmd;
        if (selCmd.op == flash_access_pkg::OP_ERASE_SEC) begin
          arrCmd.addr <= sectorBase(sector);
          arrCmd.data <= '0;
        end else if (selCmd.op == flash_access_pkg::OP_ERASE_ALL) begin
          arrCmd.addr <= ARRAY_BASE[15:0];
          arrCmd.data <= '0;
        end
      end else if (goUnprot) begin
        arrCmd.op   <= flash_access_pkg::OP_ERASE_ALL;
        arrCmd.addr <= ARRAY_BASE[15:0];
        arrCmd.data <= '0;
      end
    end
  end

  // Protection: option read after reset release, then option writes
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      protect_r <= 1'b1;
      loaded_r  <= 1'b0;
    end else if (!loaded_r) begin
      loaded_r  <= 1'b1;
      protect_r <= IS_ROM ? ROM_PROTECT : optionProtect;
    end else if (goOptSet) begin
      protect_r <= 1'b1;
    end else if (state_r == ST_UNPROT && finish) begin
      protect_r <= 1'b0;
    end
  end

  // Processor completion; refusals answer at once
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      ownerCpu_r <= 1'b0;
      cpuDone    <= 1'b0;
      cpuRefused <= 1'b0;
    end else begin
      if (takeCpu) begin
        ownerCpu_r <= 1'b1;
      end else if (takeLink) begin
        ownerCpu_r <= 1'b0;
      end
      cpuDone    <= (takeCpu & !goWrite) |
                    (state_r == ST_WAIT & finish & ownerCpu_r);
      cpuRefused <= takeCpu & !allowed;
    end
  end

  // Detector and readout gates follow protection
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      lowVoltageDetectorEn <= 1'b0;
      readoutEnable        <= 1'b0;
      readoutProtected     <= 1'b1;
    end else begin
      lowVoltageDetectorEn <= lowVoltageDetectorReq &
                              (IS_ROM | !protect_r);
      readoutEnable        <= !protect_r;
      readoutProtected     <= protect_r;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  property p_noSector0FromCpu;
    takeCpu && goWrite |=> arrStart && arrCmd.addr < flash_access_pkg::SEC0_BASE
      && arrCmd.op != flash_access_pkg::OP_ERASE_ALL;
  endproperty
  a_noSector0FromCpu: assert property (p_noSector0FromCpu)
    else $error("Processor reached sector 0");

  property p_protectBlocksWrite;
    arrStart && $past(state_r) == ST_IDLE && $past(!goUnprot) |->
      $past(!protect_r);
  endproperty
  a_protectBlocksWrite: assert property (p_protectBlocksWrite)
    else $error("Write reached array while protected");

  property p_unprotErasesFirst;
    $fell(protect_r) && loaded_r && $past(loaded_r) |->
      $past(state_r) == ST_UNPROT && arrCmd.op == flash_access_pkg::OP_ERASE_ALL;
  endproperty
  a_unprotErasesFirst: assert property (p_unprotErasesFirst)
    else $error("Protection lifted without full erase");

  property p_unprotStart;
    goUnprot |=> arrStart ##1 state_r == ST_UNPROT && protect_r;
  endproperty
  a_unprotStart: assert property (p_unprotStart)
    else $error("Full erase not started on protection removal");

  property p_lvdOff;
    !IS_ROM && protect_r && $past(protect_r) |-> !lowVoltageDetectorEn;
  endproperty
  a_lvdOff: assert property (p_lvdOff)
    else $error("Detector enabled under protection");

  property p_pinsTaken;
    attached |-> !toolSerialClockOe && !appDataIn &&
      toolSerialDataOe == (linkOe && sessionOn);
  endproperty
  a_pinsTaken: assert property (p_pinsTaken)
    else $error("Application still on tool pins");

  property p_sectorErase;
    goWrite && selCmd.op == flash_access_pkg::OP_ERASE_SEC |=>
      arrCmd.addr == sectorBase($past(sector)) && $past(sector) < SECTORS;
  endproperty
  a_sectorErase: assert property (p_sectorErase)
    else $error("Sector erase aimed beyond its sector");

  property p_refusedIgnored;
    (takeLink || takeCpu) && !allowed |=> !arrStart && state_r == ST_IDLE;
  endproperty
  a_refusedIgnored: assert property (p_refusedIgnored)
    else $error("Forbidden request reached the array");

  property p_cpuNeedsLoader;
    takeCpu && !bootInSector0 |=> cpuRefused && cpuDone && !arrStart;
  endproperty
  a_cpuNeedsLoader: assert property (p_cpuNeedsLoader)
    else $error("Processor write outside loader accepted");

  c_cpuProgram: cover property (takeCpu && goWrite ##[1:50] cpuDone);
  c_linkProgram: cover property (takeLink && goWrite);
  c_unprotect: cover property (goUnprot ##[1:200] $fell(protect_r));
  c_refused: cover property (takeCpu && !allowed);

endmodule : flash_sector_access_protection

/* logic/tool_link_port.sv */
// Serial tool link receiver on the tool's own clock
`timescale 1ns/100ps
module tool_link_port (
  input  wire logic                        linkClk,
  input  wire logic                        sessionOn,
  input  wire logic                        readyLevel,
  input  wire logic                        dataIn,
  output logic                             dataOut,
  output logic                             dataOe,
  output logic                             frameTgl,
  output flash_access_pkg::arr_cmd_type    frameWord
);

  logic [1:0]                         sessSync_r;
  logic [1:0]                         rdySync_r;
  logic [4:0]                         bitCnt_r;
  logic [flash_access_pkg::CMD_W-2:0] shift_r;

  // Levels from the system domain, two flops each
  always_ff @(posedge linkClk) begin
    sessSync_r <= {sessSync_r[0], sessionOn};
    rdySync_r  <= {rdySync_r[0], readyLevel};
  end

  // Frame sequencer; session off clears it, but only on link clock edges
  always_ff @(posedge linkClk) begin
    if (!sessSync_r[1]) begin
      bitCnt_r <= flash_access_pkg::LINK_IDLE;
    end else if (bitCnt_r == flash_access_pkg::LINK_IDLE) begin
      if (dataIn) begin
        bitCnt_r <= bitCnt_r + 5'h01;
      end
    end else if (bitCnt_r == flash_access_pkg::LINK_RESP) begin
      bitCnt_r <= flash_access_pkg::LINK_IDLE;
    end else begin
      bitCnt_r <= bitCnt_r + 5'h01;
    end
  end

  // Payload shift and word hand-off by toggle
  always_ff @(posedge linkClk) begin
    if (!sessSync_r[1]) begin
      shift_r   <= '0;
      frameTgl  <= 1'b0;
      frameWord <= '0;
    end else if (bitCnt_r != flash_access_pkg::LINK_IDLE &&
                 bitCnt_r != flash_access_pkg::LINK_RESP) begin
      shift_r <= {shift_r[flash_access_pkg::CMD_W-3:0], dataIn};
      if (bitCnt_r == flash_access_pkg::LINK_LAST) begin
        frameWord <= {shift_r, dataIn};
        frameTgl  <= ~frameTgl;
      end
    end
  end

  // Device drives the data pin only in the response slot
  assign dataOe  = (bitCnt_r == flash_access_pkg::LINK_RESP);
  assign dataOut = rdySync_r[1];

  property p_respSlot;
    @(posedge linkClk) disable iff (!sessSync_r[1])
      dataOe |-> $past(bitCnt_r) == flash_access_pkg::LINK_LAST ##1 !dataOe;
  endproperty
  a_respSlot: assert property (p_respSlot)
    else $error("Data pin driven outside response slot");

endmodule : tool_link_port

/* tb/tb.sv */
// Self-checking bench for sector gating, protection and the tool link
`timescale 1ns/100ps
module tb;
  localparam int          KB    = 60;
  localparam logic [15:0] FLOOR =
    16'(flash_access_pkg::ADDR_SPAN - KB * flash_access_pkg::KBYTE);

  logic clk, rst_b, toolSerialClock, toolLine, toolSerialDataOut;
  logic toolSerialDataOe, toolSerialClockOut, toolSerialClockOe;
  logic programmingVoltageSelect, toolAttached, socketMode, appDataOut;
  logic appDataOe, appDataIn, appClockOut, appClockOe, bootInSector0;
  logic cpuReqValid, cpuReqReady, cpuDone, cpuRefused, arrStart, arrBusy;
  logic optionProtect, lowVoltageDetectorReq, lowVoltageDetectorEn;
  logic readoutEnable, readoutProtected, prot;
  wire logic toolSerialDataIn;
  flash_access_pkg::arr_cmd_type cpuReq, arrCmd, lastCmd;
  int n_errors, comparisons, nStarts, busyCnt;

  // Data pin: the enabled party drives, otherwise the tool's line
  assign toolSerialDataIn = toolSerialDataOe ? toolSerialDataOut : toolLine;

  flash_sector_access_protection #(
    .FLASH_KB(KB)
  ) u_flash_sector_access_protection (
    .clk, .rst_b, .toolSerialClock, .toolSerialDataIn, .toolSerialDataOut,
    .toolSerialDataOe, .toolSerialClockOut, .toolSerialClockOe,
    .programmingVoltageSelect, .toolAttached, .socketMode, .appDataOut,
    .appDataOe, .appDataIn, .appClockOut, .appClockOe, .bootInSector0,
    .cpuReqValid, .cpuReq, .cpuReqReady, .cpuDone, .cpuRefused, .arrStart,
    .arrCmd, .arrBusy, .optionProtect, .lowVoltageDetectorReq,
    .lowVoltageDetectorEn, .readoutEnable, .readoutProtected
  );

  tool_link_model u_tool_link_model (
    .linkClk(toolSerialClock), .session(programmingVoltageSelect),
    .line(toolLine), .devOe(toolSerialDataOe), .pin(toolSerialDataIn)
  );

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // Array model: busy from the edge that takes the start, random length
  always @(posedge clk) begin
    if (!rst_b) begin
      arrBusy <= 1'b0;
      busyCnt <= 0;
    end else if (arrStart === 1'b1) begin
      nStarts <= nStarts + 1;
      lastCmd <= arrCmd;
      arrBusy <= 1'b1;
      busyCnt <= 2 + $urandom % 4;
    end else if (busyCnt > 0) begin
      busyCnt <= busyCnt - 1;
    end else begin
      arrBusy <= 1'b0;
    end
  end

  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic complete_run();
    $display("comparisons %0d n_errors %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : complete_run

  function automatic flash_access_pkg::arr_cmd_type mk(
    input logic [2:0] op, input logic [15:0] a, input logic [7:0] d);
    mk.op   = flash_access_pkg::op_type'(op);
    mk.addr = a;
    mk.data = d;
  endfunction : mk

  // Processor may write below sector 0 and above the floor only
  function automatic bit cpu_ok(input flash_access_pkg::arr_cmd_type c,
                                input logic boot);
    return boot && !prot && (c.op inside {3'h1, 3'h2}) &&
           c.addr >= FLOOR && c.addr < 16'hF000;
  endfunction : cpu_ok

  // Erase commands carry the sector base and no data
  function automatic logic [26:0] exp_cmd(
    input flash_access_pkg::arr_cmd_type c);
    logic [15:0] b;
    b = c.addr >= 16'hF000 ? 16'hF000 : c.addr >= 16'hE000 ? 16'hE000 : FLOOR;
    if (c.op == 3'h3) return {3'h3, FLOOR, 8'h00};
    return c.op == 3'h2 ? {3'h2, b, 8'h00} : c;
  endfunction : exp_cmd

  task automatic do_reset(input logic optBit);
    #1 rst_b = 1'b0;
    optionProtect = optBit;
    repeat (3) @(posedge clk);
    #1 rst_b = 1'b1;
    prot = optBit;
    repeat (3) @(posedge clk);
    #1;
    check("protected", readoutProtected, optBit);
    check("readout", readoutEnable, !optBit);
    check("lvdEn", lowVoltageDetectorEn, !optBit);
  endtask : do_reset

  // Request held until taken, then one answer per request
  task automatic cpu_op(input flash_access_pkg::arr_cmd_type c,
                        input logic boot);
    int n0;
    int k;
    bit exp;
    n0 = nStarts;
    exp = cpu_ok(c, boot);
    @(posedge clk);
    #1 cpuReq = c;
    bootInSector0 = boot;
    cpuReqValid = 1'b1;
    k = 0;
    do begin
      @(negedge clk);
      k++;
    end while (cpuReqReady !== 1'b1 && k < 50);
    @(posedge clk);
    #1 cpuReqValid = 1'b0;
    k = 0;
    while (cpuDone !== 1'b1 && k < 50) begin
      @(negedge clk);
      k++;
    end
    check("cpuRefused", cpuRefused, !exp);
    repeat (2) @(posedge clk);
    check("cpuStarts", nStarts - n0, exp);
    if (exp) check("cpuCmd", lastCmd, exp_cmd(c));
  endtask : cpu_op

  // Frames spaced well beyond the capture time of the system side
  task automatic link_op(input flash_access_pkg::arr_cmd_type c,
                         input bit exp);
    int n0;
    n0 = nStarts;
    u_tool_link_model.send_frame(c);
    check("response", u_tool_link_model.respOe, 1'b1);
    check("ready", u_tool_link_model.respVal, 1'b1);
    repeat (70) @(posedge clk);
    check("linkStarts", nStarts - n0, exp);
    if (exp) check("linkCmd", lastCmd, exp_cmd(c));
  endtask : link_op

  initial begin
    int n0;
    int k;
    rst_b = 1'b0;
    toolAttached = 1'b0;
    socketMode = 1'b0;
    appDataOut = 1'b1;
    appDataOe = 1'b1;
    appClockOut = 1'b1;
    appClockOe = 1'b1;
    bootInSector0 = 1'b1;
    cpuReqValid = 1'b0;
    cpuReq = '0;
    optionProtect = 1'b0;
    lowVoltageDetectorReq = 1'b1;
    prot = 1'b0;
    void'($urandom(65326));
    do_reset(1'b0);
    check("clkOeFree", toolSerialClockOe, 1'b1);
    check("dataOeFree", toolSerialDataOe, 1'b1);
    check("clkOut", toolSerialClockOut, 1'b1);
    toolAttached = 1'b1;
    repeat (4) @(posedge clk);
    #1;
    check("clkOeTool", toolSerialClockOe, 1'b0);
    check("dataOeTool", toolSerialDataOe, 1'b0);
    check("appDataIn", appDataIn, 1'b0);
    toolAttached = 1'b0;
    cpu_op(mk(3'h1, 16'hF000, 8'h5A), 1'b1);
    cpu_op(mk(3'h1, 16'hEFFF, 8'hC3), 1'b1);
    cpu_op(mk(3'h2, 16'hE123, 8'h00), 1'b1);
    cpu_op(mk(3'h2, FLOOR, 8'h00), 1'b1);
    cpu_op(mk(3'h1, FLOOR - 16'h0001, 8'h01), 1'b1);
    cpu_op(mk(3'h3, 16'h2000, 8'h00), 1'b1);
    cpu_op(mk(3'h4, 16'h0000, 8'h00), 1'b1);
    cpu_op(mk(3'h1, 16'h3000, 8'h77), 1'b0);
    for (int i = 0; i < 12; i++)
      cpu_op(mk(3'($urandom_range(1, 4)), 16'($urandom), 8'($urandom)),
             $urandom_range(0, 3) != 0);
    do_reset(1'b1);
    cpu_op(mk(3'h1, 16'hE000, 8'h11), 1'b1);
    // Tool owns reset for the whole session; none is issued here
    #1 toolAttached = 1'b1;
    u_tool_link_model.open_session();
    link_op(mk(3'h1, 16'hF000, 8'hA5), 1'b0);
    n0 = nStarts;
    u_tool_link_model.send_frame(mk(3'h4, 16'h0000, 8'h00));
    k = 0;
    while (nStarts == n0 && k < 200) begin
      @(negedge clk);
      k++;
    end
    check("eraseAll", lastCmd, {3'h3, FLOOR, 8'h00});
    check("stillProt", readoutProtected, 1'b1);
    repeat (30) @(posedge clk);
    #1;
    check("unprot", readoutProtected, 1'b0);
    check("readoutOn", readoutEnable, 1'b1);
    check("lvdBack", lowVoltageDetectorEn, 1'b1);
    prot = 1'b0;
    link_op(mk(3'h1, 16'hF000, 8'hA5), 1'b1);
    link_op(mk(3'h2, 16'hF456, 8'h00), 1'b1);
    link_op(mk(3'h4, 16'h0000, 8'h01), 1'b0);
    check("reProt", readoutProtected, 1'b1);
    complete_run();
  end

  // Run is well under a thousand cycles; this limit is far beyond it
  initial begin
    #1_000_000;
    n_errors++;
    complete_run();
  end
endmodule : tb

/* tb/tool_link_model.sv */
// Programming tool model: link clock, serial data and session level
`timescale 1ns/100ps
module tool_link_model (
  output logic      linkClk,
  output logic      session,
  output logic      line,
  input  wire logic devOe,
  input  wire logic pin
);
  logic respOe;
  logic respVal;

  // Idle tool: clock parked low, session off
  initial begin
    linkClk = 1'b0;
    session = 1'b0;
    line    = 1'b0;
    respOe  = 1'b0;
    respVal = 1'b0;
  end

  // One link cycle; data moves while low, device samples on the rise
  task automatic tick();
    #7.5 linkClk = 1'b1;
    #7.5 linkClk = 1'b0;
  endtask : tick

  // Edges with session low load sessSync_r low; the first edges after the session is raised clear the link side
  task automatic open_session();
    session = 1'b0;
    repeat (2) tick();
    session = 1'b1;
    // Level crosses to the system side first, then is clocked in here
    #300;
    repeat (2) tick();
  endtask : open_session

  // Start bit, command MSB first, then the device's response slot
  task automatic send_frame(input flash_access_pkg::arr_cmd_type cmd);
    logic [27:0] bits;
    bits = {1'b1, cmd};
    for (int i = 27; i >= 0; i--) begin
      line = bits[i];
      tick();
    end
    line = ~bits[0]; // Released line never keeps the last bit
    respOe  = devOe;
    respVal = pin;
    tick();
    line = 1'b0; // Idle level, so no false start bit follows
    tick();
  endtask : send_frame
endmodule : tool_link_model
